/* ic_fetch.sv */
// Chosen here: the plain strobed port and the address map.
module ic_fetch #(
   parameter logic [15:0] cached_mask = ic_pkg::CACHED_DEF
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   input wire logic fetch_super,
   input wire logic ctl_xfer,
   input wire logic iu_busy,
   output logic fetch_valid,
   output logic fetch_trap,
   output logic [31:0] fetch_pc,
   output logic [31:0] fetch_data,
   output logic [7:0] trap_type_code,
   output logic iu_hold,
   input wire logic flush_insn,
   input wire logic [15:0] pnp_cachable,
   input wire logic dreq,
   input wire logic [31:0] daddr,
   input wire logic dwrite,
   input wire logic [1:0] dsize,
   input wire logic ddouble,
   input wire logic [31:0] dwdata,
   input wire logic [31:0] dwdata2,
   input wire logic [7:0] dasi,
   input wire logic dsuper,
   output logic dack,
   output logic derr,
   output logic [31:0] drdata,
   output logic dc_flush,
   output logic dc_diag,
   output logic hbusreq,
   input wire logic hgrant,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [2:0] hburst,
   output logic [3:0] hprot,
   output logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hready,
   input wire logic [1:0] hresp
);
   import ic_pkg::*;

   typedef enum logic [1:0] {S_IDLE, S_REQ, S_BUS} ic_state_type;
   ic_state_type state;
   logic [31:0] tags [WAYS][LINES];
   logic [31:0] dmem [WAYS][LINES*WPL];
   logic [31:0] ctrl;
   logic [31:0] fault;
   logic [31:0] ctrl_view;
   logic [LINES-1:0] mru;
   logic rnd;
   logic flushing;
   logic [4:0] fl_cnt;
   logic fl_start;
   logic job_data;
   logic upd;
   logic strm;
   logic first;
   logic dph;
   logic fway;
   logic [4:0] fline;
   logic [31:0] d_addr;
   logic [3:0] a_left;
   logic [31:0] wd0;
   logic [31:0] wd1;
   logic [4:0] line;
   logic [2:0] word;
   logic [5:0] asi;
   logic hit;
   logic hway;
   logic tmatch;
   logic tway;
   logic vway;
   logic fway_n;
   logic use_c;
   logic miss_upd;
   logic beat;
   logic ok;
   logic d_take;

   // ************
   // helpers
   // ************
   // static cachability of a 256 Mbyte block
   function automatic logic cachable(input logic [31:0] a);
      return (cached_mask != 16'h0000) ? cached_mask[a[31:28]] : pnp_cachable[a[31:28]];
   endfunction

   // victim way for a line
   function automatic logic pick_way(input logic [4:0] ln);
      logic v;
      v = rnd;
      case (REPL)
         RPL_LRR: v = tags[0][ln][TAG_LRR];
         RPL_LRU: v = ~mru[ln];
         default: v = rnd;
      endcase
      if (LOCK_EN && tags[v][ln][TAG_LOCK]) begin
         v = ~v;
      end
      return v;
   endfunction

   // ************
   // lookup
   // ************
   assign line = fetch_addr[9:5];
   assign word = fetch_addr[4:2];
   assign asi = dasi[5:0];
   assign beat = (state == S_BUS) && dph && hready;
   assign ok = (hresp == HR_OKAY);
   assign d_take = (state == S_IDLE) && !fetch_req && dreq;
   assign ctrl_view = {ctrl[31:10], state != S_IDLE, flushing, ctrl[7:0]};

   // hit and tag-match search over the ways
   always_comb begin
      hit = 1'b0;
      hway = 1'b0;
      tmatch = 1'b0;
      tway = 1'b0;
      for (int i = 0; i < WAYS; i++) begin
         if (tags[i][line][31:10] == fetch_addr[31:10]) begin
            tmatch = 1'b1;
            tway = i[0];
            if (tags[i][line][word]) begin
               hit = 1'b1;
               hway = i[0];
            end
         end
      end
   end

   // cache use, update permission and fill way
   assign use_c = ctrl[0] && !flushing && cachable(fetch_addr);
   assign miss_upd = (ctrl[1:0] == ICS_ON) && !flushing && cachable(fetch_addr);
   assign vway = pick_way(line);
   assign fway_n = tmatch ? tway : vway;

   // flush triggers
   assign fl_start = flush_insn || (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTL_FLUSH])
      || (d_take && dwrite && asi == ASI_IFL);
   assign hbusreq = (state == S_REQ) || (state == S_BUS && a_left > 4'h1);
   assign iu_hold = (state != S_IDLE);
   assign trap_type_code = TT_IACC;

   // ************
   // access sequencer and bus master
   // ************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_IDLE;
         job_data <= 1'b0;
         upd <= 1'b0;
         strm <= 1'b0;
         first <= 1'b0;
         dph <= 1'b0;
         fway <= 1'b0;
         fline <= 5'h00;
         d_addr <= 32'h0000_0000;
         a_left <= 4'h0;
         wd0 <= 32'h0000_0000;
         wd1 <= 32'h0000_0000;
         fault <= 32'h0000_0000;
         haddr <= 32'h0000_0000;
         htrans <= HT_IDLE;
         hwrite <= 1'b0;
         hsize <= HS_WORD;
         hburst <= HB_SINGLE;
         hprot <= 4'h0;
         hwdata <= 32'h0000_0000;
         fetch_valid <= 1'b0;
         fetch_trap <= 1'b0;
         fetch_pc <= 32'h0000_0000;
         fetch_data <= 32'h0000_0000;
         dack <= 1'b0;
         derr <= 1'b0;
         drdata <= 32'h0000_0000;
         dc_flush <= 1'b0;
         dc_diag <= 1'b0;
      end else begin
         fetch_valid <= 1'b0;
         fetch_trap <= 1'b0;
         dack <= 1'b0;
         derr <= 1'b0;
         dc_flush <= 1'b0;
         dc_diag <= 1'b0;
         case (state)
            S_IDLE: begin
               if (fetch_req && hit && use_c) begin
                  fetch_valid <= 1'b1;
                  fetch_pc <= fetch_addr;
                  fetch_data <= dmem[hway][{line, word}];
               end else if (fetch_req) begin
                  state <= S_REQ;
                  job_data <= 1'b0;
                  haddr <= fetch_addr;
                  a_left <= ctrl[CTL_IB] ? 4'(WPL) - {1'b0, word} : 4'h1;
                  hburst <= ctrl[CTL_IB] ? HB_INCR : HB_SINGLE;
                  hsize <= HS_WORD;
                  hwrite <= 1'b0;
                  hprot <= {cachable(fetch_addr), 1'b0, fetch_super, 1'b0};
                  upd <= miss_upd;
                  strm <= 1'b1;
                  first <= 1'b1;
                  fway <= fway_n;
                  fline <= line;
               end else if (dreq && (asi == ASI_FMISS || (asi >= ASI_NRM_LO && asi <= ASI_NRM_HI))) begin
                  state <= S_REQ;
                  job_data <= 1'b1;
                  haddr <= daddr;
                  a_left <= ddouble ? 4'h2 : 4'h1;
                  hburst <= ddouble ? HB_INCR : HB_SINGLE;
                  hsize <= ddouble ? HS_WORD : {1'b0, dsize};
                  hwrite <= dwrite;
                  hprot <= {cachable(daddr), 1'b0, dsuper, 1'b1};
                  wd0 <= dwdata;
                  wd1 <= dwdata2;
                  upd <= 1'b0;
                  strm <= 1'b0;
               end else if (dreq) begin
                  // local spaces answer in one cycle
                  if ((asi == ASI_ITAG || asi == ASI_IDAT) && flushing) begin
                     derr <= 1'b1;
                  end else begin
                     dack <= 1'b1;
                  end
                  if (asi == ASI_CTRL) begin
                     drdata <= ctrl_view;
                  end else if (asi == ASI_ITAG) begin
                     drdata <= tags[daddr[10]][daddr[9:5]];
                  end else if (asi == ASI_IDAT) begin
                     drdata <= dmem[daddr[10]][daddr[9:2]];
                  end else begin
                     drdata <= 32'h0000_0000;
                  end
                  dc_diag <= (asi == ASI_DTAG || asi == ASI_DDAT);
                  dc_flush <= (asi == ASI_DFL) && dwrite;
               end
            end
            S_REQ: begin
               if (hgrant && hready) begin
                  state <= S_BUS;
                  htrans <= HT_NSEQ;
               end
            end
            default: begin
               if (hready) begin
                  dph <= (htrans != HT_IDLE);
                  d_addr <= haddr;
                  hwdata <= (htrans == HT_SEQ) ? wd1 : wd0;
                  if (htrans != HT_IDLE && a_left > 4'h1 && !(ctl_xfer && !job_data)) begin
                     haddr <= haddr + 32'h0000_0004;
                     htrans <= HT_SEQ;
                     a_left <= a_left - 4'h1;
                  end else begin
                     htrans <= HT_IDLE;
                     a_left <= 4'h0;
                  end
                  if (dph && htrans == HT_IDLE) begin
                     state <= S_IDLE;
                  end
               end else if (hresp != HR_OKAY) begin
                  htrans <= HT_IDLE;
                  a_left <= 4'h0;
               end
               // completed data beat
               if (beat && job_data) begin
                  dack <= ok;
                  derr <= !ok;
                  drdata <= hrdata;
               end else if (beat) begin
                  fetch_pc <= d_addr;
                  fetch_data <= hrdata;
                  fetch_valid <= strm && ok && !iu_busy && !ctl_xfer;
                  fetch_trap <= first && !ok;
                  first <= 1'b0;
                  if (!ok) begin
                     fault <= d_addr;
                  end
               end
               if (ctl_xfer || iu_busy || (beat && !ok)) begin
                  strm <= 1'b0;
               end
            end
         endcase
         if (fl_start) begin
            upd <= 1'b0;
         end
      end
   end

   // ************
   // tag store
   // ************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < WAYS; i++) begin
            for (int j = 0; j < LINES; j++) begin
               tags[i][j] <= 32'h0000_0000;
            end
         end
      end else if (flushing) begin
         for (int i = 0; i < WAYS; i++) begin
            tags[i][fl_cnt][7:0] <= 8'h00;
         end
      end else if (state == S_IDLE && fetch_req && !(hit && use_c) && miss_upd && !tmatch) begin
         tags[fway_n][line][31:10] <= fetch_addr[31:10];
         tags[fway_n][line][7:0] <= 8'h00;
         if (REPL == RPL_LRR) begin
            tags[fway_n][line][TAG_LRR] <= 1'b1;
            tags[~fway_n][line][TAG_LRR] <= 1'b0;
         end
      end else if (beat && !job_data && upd && ok) begin
         tags[fway][fline][d_addr[4:2]] <= 1'b1;
      end else if (d_take && dwrite && asi == ASI_ITAG) begin
         tags[daddr[10]][daddr[9:5]] <= {dwdata[31:10], dwdata[9] & (REPL == RPL_LRR),
            dwdata[8] & LOCK_EN & (daddr[10] == 1'b0), dwdata[7:0]};
      end
   end

   // data store, no reset
   always_ff @(posedge ref_clk) begin
      if (beat && !job_data && upd && ok && !flushing) begin
         dmem[fway][{fline, d_addr[4:2]}] <= hrdata;
      end else if (d_take && dwrite && asi == ASI_IDAT && !flushing) begin
         dmem[daddr[10]][daddr[9:2]] <= dwdata;
      end
   end

   // ************
   // replacement history and flush walker
   // ************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rnd <= 1'b0;
         mru <= '0;
      end else begin
         rnd <= ~rnd; // modulo-2 counter
         if (state == S_IDLE && fetch_req && hit && use_c) begin
            mru[line] <= hway;
         end else if (state == S_IDLE && fetch_req && miss_upd) begin
            mru[line] <= fway_n;
         end
      end
   end

   // one line per cycle, cache off meanwhile
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flushing <= 1'b0;
         fl_cnt <= 5'h00;
      end else if (flushing) begin
         fl_cnt <= fl_cnt + 5'h01;
         if (fl_cnt == 5'(LINES - 1)) begin
            flushing <= 1'b0;
         end
      end else if (fl_start) begin
         flushing <= 1'b1;
         fl_cnt <= 5'h00;
      end
   end

   // ************
   // control word and register port
   // ************
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= CTRL_RST;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         ctrl <= reg_wdata & CTRL_WMASK;
      end else if (d_take && dwrite && asi == ASI_CTRL) begin
         ctrl <= dwdata & CTRL_WMASK;
      end
   end

   // read data one cycle after the strobe
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd && reg_addr == REG_CTRL) begin
         reg_rdata <= ctrl_view;
      end else if (reg_rd && reg_addr == REG_FAULT) begin
         reg_rdata <= fault;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ************
   // checks
   // ************
   chk_ctrl_asi_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (d_take && dwrite && asi == ASI_CTRL && !reg_wr) |=> ctrl[1:0] == $past(dwdata[1:0]))
      else $error("control write by alternate space lost");
   chk_hit_data: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state == S_IDLE && fetch_req && hit && use_c) |=> fetch_valid && fetch_pc == $past(fetch_addr))
      else $error("hit not answered next cycle");
   chk_fetch_burst: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state == S_IDLE && fetch_req && !(hit && use_c)) |=> hburst == ($past(ctrl[CTL_IB]) ? HB_INCR : HB_SINGLE))
      else $error("fetch burst type wrong");
   chk_double_burst: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state == S_IDLE && !fetch_req && dreq && ddouble && asi >= ASI_NRM_LO && asi <= ASI_NRM_HI)
      |=> hburst == HB_INCR && a_left == 4'h2)
      else $error("double access not a two-beat burst");
   chk_prot_kind: assert property (@(posedge ref_clk) disable iff (!arst_n)
      htrans != HT_IDLE |-> hprot[0] == job_data)
      else $error("protection data bit wrong");
   chk_lock_victim: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state == S_IDLE && fetch_req && miss_upd && !tmatch) |-> !tags[vway][line][TAG_LOCK])
      else $error("locked line chosen as victim");
   chk_flush_end: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (flushing && fl_cnt == 5'h1F) |=> !flushing ##1 !flushing)
      else $error("flush length wrong");
   chk_flush_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
      flushing |=> tags[0][$past(fl_cnt)][7:0] == 8'h00 && tags[1][$past(fl_cnt)][7:0] == 8'h00)
      else $error("flushed line still valid");
   chk_error_valid: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (beat && !job_data && !ok && !flushing) |=> !tags[fway][fline][$past(d_addr[4:2])])
      else $error("valid set after bus error");
   chk_trap_first: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (beat && !job_data && first && !ok) |=> fetch_trap && !fetch_valid && trap_type_code == TT_IACC)
      else $error("fetch error trap missing");
   chk_stream_word: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (beat && !job_data && strm && ok && !iu_busy && !ctl_xfer) |=> fetch_valid && fetch_data == $past(hrdata))
      else $error("refill word not streamed");
   chk_abandon: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (state == S_BUS && ctl_xfer && hready && !job_data) |=> htrans == HT_IDLE && !strm)
      else $error("refill not abandoned");
endmodule

/* ic_pkg.sv */
package ic_pkg;
   // ************
   // geometry and policy
   // ************
   localparam int WAYS = 2;
   localparam int LINES = 32;
   localparam int WPL = 8;
   typedef enum logic [1:0] {RPL_RANDOM, RPL_LRR, RPL_LRU} ic_repl_type;
   localparam ic_repl_type REPL = RPL_LRU;
   localparam bit LOCK_EN = 1'b1;
   localparam logic [15:0] CACHED_DEF = 16'h0000;
   localparam int TAG_LRR = 9;
   localparam int TAG_LOCK = 8;
   // ************
   // register port
   // ************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_FAULT = 4'h4;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_0023;
   localparam logic [1:0] ICS_ON = 2'h3;
   localparam int CTL_FLUSH = 4;
   localparam int CTL_IB = 5;
   // ************
   // alternate spaces and trap
   // ************
   localparam logic [5:0] ASI_FMISS = 6'h01;
   localparam logic [5:0] ASI_CTRL = 6'h02;
   localparam logic [5:0] ASI_NRM_LO = 6'h08;
   localparam logic [5:0] ASI_NRM_HI = 6'h0B;
   localparam logic [5:0] ASI_ITAG = 6'h0C;
   localparam logic [5:0] ASI_IDAT = 6'h0D;
   localparam logic [5:0] ASI_DTAG = 6'h0E;
   localparam logic [5:0] ASI_DDAT = 6'h0F;
   localparam logic [5:0] ASI_IFL = 6'h10;
   localparam logic [5:0] ASI_DFL = 6'h11;
   localparam logic [7:0] TT_IACC = 8'h01;
   // ************
   // bus encodings
   // ************
   localparam logic [1:0] HT_IDLE = 2'h0;
   localparam logic [1:0] HT_NSEQ = 2'h2;
   localparam logic [1:0] HT_SEQ = 2'h3;
   localparam logic [2:0] HB_SINGLE = 3'h0;
   localparam logic [2:0] HB_INCR = 3'h1;
   localparam logic [2:0] HS_WORD = 3'h2;
   localparam logic [1:0] HR_OKAY = 2'h0;
endpackage

/* ic_ahb_mem.sv */
module ic_ahb_mem (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic [31:0] err_addr,
   input wire logic hbusreq,
   output logic hgrant,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [3:0] hprot,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hready,
   output logic [1:0] hresp,
   output logic [31:0] last_wdata,
   output logic [3:0] last_prot
);
   timeunit 1ns;
   timeprecision 1ns;
   import ic_pkg::*;
   logic dp, dw, w, tick, bad;
   logic [31:0] da;
   // ************
   // bus slave answers
   // ************
   assign hgrant = hbusreq;
   // the chosen word answers with the two-cycle error response
   assign bad = dp && da == err_addr;
   assign hready = !(dp && !w && (slow || bad));
   assign hresp = bad ? 2'h1 : HR_OKAY;
   // data only in a read data phase, else a pattern that toggles
   assign hrdata = (dp && !dw) ? da ^ 32'h5A5A_5A5A : {32{tick}};
   // address and data phase tracking
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dp <= 1'b0;
         dw <= 1'b0;
         w <= 1'b0;
         tick <= 1'b0;
         da <= 32'h0000_0000;
         last_wdata <= 32'h0000_0000;
         last_prot <= 4'h0;
      end else begin
         tick <= !tick;
         w <= dp && !hready;
         if (hready) begin
            dp <= htrans[1]; // a slave decodes the transfer type only, grant is the arbiter's
            da <= haddr;
            dw <= hwrite;
            if (htrans[1]) last_prot <= hprot;
            if (dp && dw) last_wdata <= hwdata;
         end
      end
   end
endmodule

/* tb_ic_fetch.sv */
module tb_ic_fetch;
   timeunit 1ns;
   timeprecision 1ns;
   import ic_pkg::*;
   logic ref_clk, arst_n, reg_wr, reg_rd, fetch_req, fetch_super, ctl_xfer, iu_busy;
   logic fetch_valid, fetch_trap, iu_hold, flush_insn, dreq, dwrite, ddouble, dsuper;
   logic dack, derr, dc_flush, dc_diag, hbusreq, hgrant, hwrite, hready, slow;
   logic [1:0] dsize, htrans, hresp;
   logic [2:0] hsize, hburst;
   logic [3:0] reg_addr, hprot, last_prot;
   logic [7:0] trap_type_code, dasi;
   logic [15:0] pnp_cachable;
   logic [31:0] reg_wdata, reg_rdata, fetch_addr, fetch_pc, fetch_data, daddr, dwdata, dwdata2;
   logic [31:0] drdata, haddr, hwdata, hrdata, err_addr, last_wdata, got, t0;
   int err_total, num_checks;
   // ************
   // design and bus partner
   // ************
   ic_fetch i_ic_fetch (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .fetch_req, .fetch_addr, .fetch_super, .ctl_xfer, .iu_busy, .fetch_valid, .fetch_trap,
      .fetch_pc, .fetch_data, .trap_type_code, .iu_hold, .flush_insn, .pnp_cachable, .dreq,
      .daddr, .dwrite, .dsize, .ddouble, .dwdata, .dwdata2, .dasi, .dsuper, .dack, .derr,
      .drdata, .dc_flush, .dc_diag, .hbusreq, .hgrant, .haddr, .htrans, .hwrite, .hsize,
      .hburst, .hprot, .hwdata, .hrdata, .hready, .hresp);
   ic_ahb_mem i_ic_ahb_mem (.ref_clk, .arst_n, .slow, .err_addr, .hbusreq, .hgrant, .haddr,
      .htrans, .hwrite, .hprot, .hwdata, .hrdata, .hready, .hresp, .last_wdata, .last_prot);
   always #5 ref_clk = !ref_clk;
   task end_of_test;
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask
   // fetch one address, count streamed words and traps, note bus use
   task fet(input logic [31:0] a, input int n, input logic b, input int t);
      int k, tr;
      logic bus;
      k = 0;
      tr = 0;
      bus = 1'b0;
      @(posedge ref_clk);
      fetch_req <= 1'b1;
      fetch_addr <= a;
      @(posedge ref_clk);
      fetch_req <= 1'b0;
      for (int c = 0; c < 80; c++) begin
         #1;
         bus |= (hbusreq === 1'b1);
         if (fetch_valid === 1'b1) begin
            chk("fetch_pc", a + 4 * k, fetch_pc);
            chk("fetch_data", (a + 4 * k) ^ 32'h5A5A_5A5A, fetch_data);
            k++;
         end
         if (fetch_trap === 1'b1) begin
            chk("trap_type_code", TT_IACC, trap_type_code);
            tr++;
         end
         if (c > 2 && iu_hold !== 1'b1) break;
         @(posedge ref_clk);
      end
      chk("beats", n, k);
      chk("traps", t, tr);
      chk("bus_used", b, bus);
   endtask
   // data access, first answered word kept in got
   task dac(input logic [7:0] s, input logic [31:0] a, input logic w, input logic dd, input int n);
      int k;
      k = 0;
      @(posedge ref_clk);
      dreq <= 1'b1;
      dasi <= s;
      daddr <= a;
      dwrite <= w;
      ddouble <= dd;
      @(posedge ref_clk);
      dreq <= 1'b0;
      for (int c = 0; c < 40; c++) begin
         #1;
         if (dack === 1'b1) begin
            if (k == 0) got = drdata;
            k++;
         end
         if (c > 2 && iu_hold !== 1'b1) break;
         @(posedge ref_clk);
      end
      chk("acks", n, k);
   endtask
   // hang guard
   initial begin
      #300000;
      err_total++;
      end_of_test;
   end
   // ************
   // test sequence
   // ************
   initial begin
      {ref_clk, arst_n, reg_wr, reg_rd, fetch_req, fetch_super, ctl_xfer, iu_busy} = 8'h00;
      {flush_insn, dreq, dwrite, ddouble, dsuper, slow} = 6'h00;
      {reg_addr, reg_wdata, fetch_addr, daddr, dasi} = 0;
      pnp_cachable = 16'h0001;
      err_addr = 32'h0000_0200;
      dsize = 2'h2;
      dwdata = 32'hCAFE_0001;
      dwdata2 = 32'hCAFE_0002;
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(REG_CTRL, CTRL_RST);
      rd(4'hC, 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_0023);
      rd(REG_CTRL, 32'h0000_0023);
      fet(32'h0000_0010, 4, 1, 0);
      chk("hprot_fetch", 4'h8, last_prot);
      fet(32'h0000_001C, 1, 0, 0);
      dac(8'h0C, 32'h0000_0000, 0, 0, 1);
      t0 = got;
      dac(8'h4C, 32'h0000_0400, 0, 0, 1);
      chk("tag_line0", 32'h0000_00F0, t0 | got);
      dwdata <= 32'h0000_2500;
      dac(8'h0C, 32'h0000_0020, 1, 0, 1);
      slow <= 1'b1;
      fet(32'h0000_0C20, 8, 1, 0);
      fet(32'h0000_1020, 8, 1, 0);
      slow <= 1'b0;
      dac(8'h0C, 32'h0000_0020, 0, 0, 1);
      chk("tag_locked", 32'h0000_2500, got);
      dac(8'h0C, 32'h0000_0420, 0, 0, 1);
      chk("tag_way1", 32'h0000_10FF, got);
      @(posedge ref_clk);
      flush_insn <= 1'b1;
      @(posedge ref_clk);
      flush_insn <= 1'b0;
      repeat (40) @(posedge ref_clk);
      fet(32'h0000_001C, 1, 1, 0);
      rd(REG_CTRL, 32'h0000_0023);
      // control transfer kills the burst after its first address, the word still lands
      ctl_xfer <= 1'b1;
      fet(32'h0000_0080, 0, 1, 0);
      ctl_xfer <= 1'b0;
      fet(32'h0000_0080, 1, 0, 0);
      // busy unit gets nothing streamed but the words from the fetched one to the line end still fill
      iu_busy <= 1'b1;
      fet(32'h0000_0098, 0, 1, 0);
      iu_busy <= 1'b0;
      fet(32'h0000_009C, 1, 0, 0);
      wr(REG_CTRL, 32'h0000_0020);
      fet(32'h0000_0078, 2, 1, 0);
      fet(32'h0000_0078, 2, 1, 0);
      wr(REG_CTRL, 32'h0000_0003);
      fet(32'h0000_0200, 0, 1, 1);
      fet(32'h0000_0200, 0, 1, 1);
      rd(REG_FAULT, 32'h0000_0200);
      fet(32'h0000_0240, 1, 1, 0);
      fetch_super <= 1'b1;
      fet(32'h3000_0000, 1, 1, 0);
      fet(32'h3000_0000, 1, 1, 0);
      chk("hprot_fetch", 4'h2, last_prot);
      dac(8'hC2, 32'h0000_0000, 0, 0, 1);
      chk("ctrl_alias", 32'h0000_0003, got);
      dsuper <= 1'b1;
      dac(8'h0B, 32'h0000_0100, 1, 0, 1);
      chk("hwdata", 32'h0000_2500, last_wdata);
      chk("hprot_data", 4'hB, last_prot);
      dac(8'h0A, 32'h0000_0300, 0, 1, 2);
      chk("drdata", 32'h0000_0300 ^ 32'h5A5A_5A5A, got);
      dac(8'h01, 32'h0000_0104, 0, 0, 1);
      chk("drdata", 32'h0000_0104 ^ 32'h5A5A_5A5A, got);
      dwdata <= 32'h0000_0021;
      dac(8'h02, 32'h0000_0000, 1, 0, 1);
      rd(REG_CTRL, 32'h0000_0021);
      end_of_test;
   end
endmodule
